//--- src/ach_coil_handler.sv
// Single-coil write command handler for brake release, motion hold and
// home return, fed by a byte stream from a serial receiver on ref_clk_i.
// Assumes receiver and transmitter byte ports on the same clock; the
// teaching tool presence pin is asynchronous.
`timescale 1ns/100ps
`include "ach_map.svh"
module ach_coil_handler
#(
  parameter int SILENT_NS = `ACH_SILENT_NS
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Station identity
  input wire logic [3:0] axis_i,
  // Receive byte stream
  input wire logic rx_valid_i,
  input wire ach_pkg::ach_byte_t rx_data_i,
  // Transmit byte stream
  output logic tx_valid_o,
  output ach_pkg::ach_byte_t tx_data_o,
  input wire logic tx_ready_i,
  // Motion engine status
  input wire logic servo_on_i,
  input wire logic moving_i,
  input wire logic alarm_reset_i,
  input wire logic home_reversed_i,
  input wire logic home_finished_i,
  // Teaching tool presence pin
  input wire logic teach_present_i,
  // Motion engine commands
  output logic brake_release_o,
  output logic motion_hold_o,
  output logic move_inhibit_o,
  output logic resume_o,
  output logic discard_remaining_o,
  output logic home_start_o,
  output logic home_restart_o,
  output logic homing_done_flag_o,
  output logic servo_cmd_lock_o
);
  import ach_pkg::*;

  localparam int SILENT_CYC_INT = (SILENT_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS;
  localparam logic [31:0] SILENT_CYC = SILENT_CYC_INT[31:0];

  ////////////////////////////////////////////////////////////////////////////
  // Receive framing

  ach_byte_t rx_buf [0:7];
  logic [31:0] gap_cnt_reg;
  logic in_frame_reg;
  logic [3:0] rx_cnt_reg;
  logic [15:0] rx_crc;
  logic frame_end;
  logic frame_ok;
  logic accept;
  logic rx_store;

  assign rx_store = rx_valid_i && (rx_cnt_reg < `ACH_FRAME_LEN);
  assign frame_end = in_frame_reg && !rx_valid_i && (gap_cnt_reg >= SILENT_CYC - 32'h1);
  assign frame_ok = frame_end && (rx_cnt_reg == `ACH_FRAME_LEN)
                    && (rx_crc == `ACH_CRC_GOOD);

  ach_crc16 u_rx_crc
  (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .clear_i(frame_end),
    .en_i(rx_store),
    .byte_i(rx_data_i),
    .crc_o(rx_crc)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      gap_cnt_reg <= 32'h0;
      in_frame_reg <= 1'b0;
      rx_cnt_reg <= 4'h0;
    end
    else if (rx_valid_i)
    begin
      gap_cnt_reg <= 32'h0;
      in_frame_reg <= 1'b1;
      if (rx_cnt_reg <= `ACH_FRAME_LEN)
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
    else if (frame_end)
    begin
      in_frame_reg <= 1'b0;
      rx_cnt_reg <= 4'h0;
    end
    else if (gap_cnt_reg < SILENT_CYC)
      gap_cnt_reg <= gap_cnt_reg + 32'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rx_store)
      rx_buf[rx_cnt_reg[2:0]] <= rx_data_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query decode

  ach_byte_t q_slave;
  ach_byte_t q_func;
  logic [15:0] q_coil;
  logic [15:0] q_data;
  ach_byte_t my_addr;
  logic addr_hit;
  logic bcast;
  logic coil_known;
  logic data_ok;
  ach_byte_t exc_code;
  logic act;
  logic reply;
  logic tx_idle;

  assign q_slave = rx_buf[`ACH_IDX_SLAVE];
  assign q_func = rx_buf[`ACH_IDX_FUNC];
  assign q_coil = {rx_buf[`ACH_IDX_COIL_HI], rx_buf[`ACH_IDX_COIL_LO]};
  assign q_data = {rx_buf[`ACH_IDX_DATA_HI], rx_buf[`ACH_IDX_DATA_LO]};
  assign my_addr = {4'h0, axis_i} + `ACH_ADDR_OFFSET;
  assign addr_hit = (q_slave == my_addr);
  assign bcast = (q_slave == `ACH_ADDR_BCAST);
  assign coil_known = (q_coil == `ACH_COIL_BRAKE) || (q_coil == `ACH_COIL_HOLD)
                      || (q_coil == `ACH_COIL_HOME);
  assign data_ok = (q_data == `ACH_DATA_ON) || (q_data == `ACH_DATA_OFF);
  assign exc_code = (q_func != `ACH_FUNC_WR_COIL) ? `ACH_EXC_FUNC :
                    (!coil_known) ? `ACH_EXC_ADDR :
                    (!data_ok) ? `ACH_EXC_DATA : `ACH_EXC_NONE;
  assign accept = frame_ok && tx_idle && (addr_hit || bcast);
  assign act = accept && (exc_code == `ACH_EXC_NONE);
  assign reply = accept && addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Coil state

  logic brake_coil_reg;
  logic hold_coil_reg;
  logic home_coil_reg;
  logic data_on;
  logic home_rise;
  logic hold_rise;
  logic hold_fall;

  assign data_on = (q_data == `ACH_DATA_ON);
  assign home_rise = act && (q_coil == `ACH_COIL_HOME) && data_on && !home_coil_reg;
  assign hold_rise = act && (q_coil == `ACH_COIL_HOLD) && data_on && !hold_coil_reg;
  assign hold_fall = act && (q_coil == `ACH_COIL_HOLD) && !data_on && hold_coil_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      brake_coil_reg <= 1'b0;
      hold_coil_reg <= 1'b0;
      home_coil_reg <= 1'b0;
    end
    else if (act)
    begin
      if (q_coil == `ACH_COIL_BRAKE)
        brake_coil_reg <= data_on;
      if (q_coil == `ACH_COIL_HOLD)
        hold_coil_reg <= data_on;
      if (q_coil == `ACH_COIL_HOME)
        home_coil_reg <= data_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold, resume and discard

  logic remain_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      remain_reg <= 1'b0;
      resume_o <= 1'b0;
      discard_remaining_o <= 1'b0;
      brake_release_o <= 1'b0;
    end
    else
    begin
      brake_release_o <= servo_on_i || brake_coil_reg;
      resume_o <= hold_fall && remain_reg;
      discard_remaining_o <= hold_coil_reg && alarm_reset_i && remain_reg;
      if (hold_rise && moving_i)
        remain_reg <= 1'b1;
      else if (hold_fall || (hold_coil_reg && alarm_reset_i))
        remain_reg <= 1'b0;
    end
  end

  assign motion_hold_o = hold_coil_reg;
  assign move_inhibit_o = hold_coil_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Home return sequencing

  ach_home_state_t hm_state_reg;
  ach_home_state_t hm_state_next;

  always_comb
  begin
    hm_state_next = hm_state_reg;
    unique case (hm_state_reg)
      ACH_HM_IDLE:
        if (home_rise)
          hm_state_next = ACH_HM_RUN;
      ACH_HM_RUN:
        if (home_finished_i)
          hm_state_next = ACH_HM_IDLE;
        else if (hold_rise && !home_reversed_i)
          hm_state_next = ACH_HM_HELD;
      ACH_HM_HELD:
        if (hold_fall)
          hm_state_next = ACH_HM_RUN;
      default:
        hm_state_next = ACH_HM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      hm_state_reg <= ACH_HM_IDLE;
      home_start_o <= 1'b0;
      home_restart_o <= 1'b0;
      homing_done_flag_o <= 1'b0;
    end
    else
    begin
      hm_state_reg <= hm_state_next;
      home_start_o <= home_rise;
      home_restart_o <= (hm_state_reg == ACH_HM_RUN) && hold_rise && home_reversed_i;
      if ((hm_state_reg == ACH_HM_RUN) && home_finished_i)
        homing_done_flag_o <= 1'b1;
      else if (home_rise)
        homing_done_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Teaching tool lockout of servo commands

  logic teach_meta_reg;
  logic teach_sync_reg;
  logic host_seen_reg;
  logic teach_off_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      teach_meta_reg <= 1'b0;
      teach_sync_reg <= 1'b0;
      host_seen_reg <= 1'b0;
      teach_off_reg <= 1'b0;
      servo_cmd_lock_o <= 1'b0;
    end
    else
    begin
      teach_meta_reg <= teach_present_i;
      teach_sync_reg <= teach_meta_reg;
      if (accept)
        host_seen_reg <= 1'b1;
      if (teach_sync_reg && !host_seen_reg && !servo_on_i)
        teach_off_reg <= 1'b1;
      if (teach_off_reg && !teach_sync_reg)
        servo_cmd_lock_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply transmitter

  ach_byte_t tx_buf [0:5];
  ach_tx_state_t tx_state_reg;
  logic [3:0] tx_idx_reg;
  logic [3:0] tx_len_reg;
  logic [15:0] tx_crc;
  logic tx_fire;
  logic tx_data_fire;

  assign tx_idle = (tx_state_reg == ACH_TX_IDLE);
  assign tx_valid_o = !tx_idle;
  assign tx_fire = tx_valid_o && tx_ready_i;
  assign tx_data_fire = tx_fire && (tx_state_reg == ACH_TX_DATA);
  assign tx_data_o = (tx_state_reg == ACH_TX_CRCL) ? tx_crc[7:0] :
                     (tx_state_reg == ACH_TX_CRCH) ? tx_crc[15:8] :
                     (tx_state_reg == ACH_TX_DATA) ? tx_buf[tx_idx_reg[2:0]] : 8'h00;

  ach_crc16 u_tx_crc
  (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .clear_i(reply),
    .en_i(tx_data_fire),
    .byte_i(tx_buf[tx_idx_reg[2:0]]),
    .crc_o(tx_crc)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (reply)
    begin
      for (int i = 0; i < 6; i++)
        tx_buf[i] <= rx_buf[i];
      if (exc_code != `ACH_EXC_NONE)
      begin
        tx_buf[`ACH_IDX_FUNC] <= q_func | `ACH_FUNC_EXC_BIT;
        tx_buf[`ACH_IDX_COIL_HI] <= exc_code;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      tx_state_reg <= ACH_TX_IDLE;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= 4'h0;
    end
    else
    begin
      unique case (tx_state_reg)
        ACH_TX_IDLE:
          if (reply)
          begin
            tx_state_reg <= ACH_TX_DATA;
            tx_idx_reg <= 4'h0;
            tx_len_reg <= (exc_code == `ACH_EXC_NONE) ? `ACH_BODY_LEN : `ACH_EXC_LEN;
          end
        ACH_TX_DATA:
          if (tx_fire)
          begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if (tx_idx_reg == tx_len_reg - 4'h1)
              tx_state_reg <= ACH_TX_CRCL;
          end
        ACH_TX_CRCL:
          if (tx_fire)
            tx_state_reg <= ACH_TX_CRCH;
        ACH_TX_CRCH:
          if (tx_fire)
            tx_state_reg <= ACH_TX_IDLE;
      endcase
    end
  end

endmodule

//--- src/ach_crc16.sv
// Byte-serial 16-bit error check accumulator, reflected polynomial.
// Assumes one byte per enabled cycle; clear restores the seed.
`timescale 1ns/100ps
`include "ach_map.svh"
module ach_crc16
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Control
  input wire logic clear_i,
  input wire logic en_i,
  input wire ach_pkg::ach_byte_t byte_i,
  // Result
  output logic [15:0] crc_o
);
  import ach_pkg::*;

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  function automatic logic [15:0] ach_crc_step(input logic [15:0] crc, input ach_byte_t b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `ACH_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  assign crc_next = clear_i ? `ACH_CRC_INIT : (en_i ? ach_crc_step(crc_reg, byte_i) : crc_reg);
  assign crc_o = crc_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      crc_reg <= `ACH_CRC_INIT;
    else
      crc_reg <= crc_next;
  end

endmodule

//--- src/ach_map.svh
// Constant map of the coil command handler: frame layout, coil offsets,
// data codes, exception codes and timing figures.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACH_MAP_SVH
`define ACH_MAP_SVH

// Frame layout
`define ACH_FRAME_LEN 4'h8
`define ACH_BODY_LEN 4'h6
`define ACH_EXC_LEN 4'h3
`define ACH_IDX_SLAVE 3'h0
`define ACH_IDX_FUNC 3'h1
`define ACH_IDX_COIL_HI 3'h2
`define ACH_IDX_COIL_LO 3'h3
`define ACH_IDX_DATA_HI 3'h4
`define ACH_IDX_DATA_LO 3'h5

// Addressing and function
`define ACH_ADDR_BCAST 8'h00
`define ACH_ADDR_OFFSET 8'h01
`define ACH_FUNC_WR_COIL 8'h05
`define ACH_FUNC_EXC_BIT 8'h80

// Coil offsets
`define ACH_COIL_BRAKE 16'h0408
`define ACH_COIL_HOLD 16'h040a
`define ACH_COIL_HOME 16'h040b

// Coil data words
`define ACH_DATA_ON 16'hff00
`define ACH_DATA_OFF 16'h0000

// Exception codes
`define ACH_EXC_NONE 8'h00
`define ACH_EXC_FUNC 8'h01
`define ACH_EXC_ADDR 8'h02
`define ACH_EXC_DATA 8'h03

// Error check
`define ACH_CRC_INIT 16'hffff
`define ACH_CRC_POLY 16'ha001
`define ACH_CRC_GOOD 16'h0000

// Timing: clock period and silent interval (3.5 characters at 9600 baud)
`define ACH_CLK_NS 10
`define ACH_SILENT_NS 3646000

`endif

//--- src/ach_pkg.sv
// Types shared by the coil command handler modules.
// Assumes ach_map.svh on the include path.
`include "ach_map.svh"

package ach_pkg;

  typedef logic [7:0] ach_byte_t;

  typedef enum logic [1:0] {
    ACH_TX_IDLE = 2'b00,
    ACH_TX_DATA = 2'b01,
    ACH_TX_CRCL = 2'b10,
    ACH_TX_CRCH = 2'b11
  } ach_tx_state_t;

  typedef enum logic [1:0] {
    ACH_HM_IDLE = 2'b00,
    ACH_HM_RUN = 2'b01,
    ACH_HM_HELD = 2'b10
  } ach_home_state_t;

endpackage

//--- test/ach_coil_handler_asserts.sv
// Port-level checker for the coil command handler.
// Assumes binding to ach_coil_handler; single clock domain.
`timescale 1ns/100ps

module ach_coil_handler_asserts
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Inputs watched
  input wire logic servo_on_i,
  input wire logic alarm_reset_i,
  input wire logic home_reversed_i,
  input wire logic home_finished_i,
  input wire logic tx_ready_i,
  // Outputs watched
  input wire logic tx_valid_o,
  input wire ach_pkg::ach_byte_t tx_data_o,
  input wire logic brake_release_o,
  input wire logic motion_hold_o,
  input wire logic move_inhibit_o,
  input wire logic resume_o,
  input wire logic discard_remaining_o,
  input wire logic home_start_o,
  input wire logic home_restart_o,
  input wire logic homing_done_flag_o,
  input wire logic servo_cmd_lock_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  hold_inhibit_a: assert property (motion_hold_o == move_inhibit_o)
    else $error("inhibit differs from hold");
  brake_servo_a: assert property (servo_on_i |=> brake_release_o)
    else $error("brake held while servo on");
  done_set_a: assert property ($rose(homing_done_flag_o) |-> $past(home_finished_i))
    else $error("done flag without finish");
  start_clear_a: assert property (home_start_o && !home_finished_i |=> !homing_done_flag_o)
    else $error("done flag kept on new start");
  start_pulse_a: assert property (home_start_o |=> !home_start_o)
    else $error("home start longer than a cycle");
  restart_rev_a: assert property (home_restart_o |-> $past(home_reversed_i) && motion_hold_o)
    else $error("restart without reversal and hold");
  discard_hold_a: assert property (discard_remaining_o |-> $past(alarm_reset_i) && $past(motion_hold_o))
    else $error("discard without alarm reset in hold");
  resume_free_a: assert property (resume_o |-> !motion_hold_o ##1 !resume_o)
    else $error("resume while held or too long");
  lock_sticky_a: assert property (servo_cmd_lock_o |=> servo_cmd_lock_o)
    else $error("servo lock dropped");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed while stalled");
endmodule

bind ach_coil_handler ach_coil_handler_asserts u_chk (.*);

//--- test/ach_host_model.sv
// Host master model: sends coil write queries, collects replies with stalls.
// Assumes the handler's byte ports on the same clock.
`timescale 1ns/100ps

module ach_host_model
(
  // Clock
  input wire logic clk_i,
  // Reply stream
  input wire logic rsp_valid_i,
  input wire ach_pkg::ach_byte_t rsp_data_i,
  output logic rsp_ready_o,
  // Query stream
  output logic req_valid_o,
  output ach_pkg::ach_byte_t req_data_o
);
  import ach_pkg::*;
  ach_byte_t q[8];
  ach_byte_t rsp[$];

  initial
  begin
    req_valid_o = 1'b0;
    req_data_o = 8'h00;
    rsp_ready_o = 1'b0;
  end

  // One query; bad corrupts the low check byte
  task automatic send(input ach_byte_t a, f, input logic [15:0] c, d, input bit bad);
    logic [15:0] r;
    q = '{a, f, c[15:8], c[7:0], d[15:8], d[7:0], 8'h00, 8'h00};
    r = 16'hffff;
    for (int i = 0; i < 6; i++)
    begin
      r ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    q[6] = r[7:0] ^ {7'h00, bad};
    q[7] = r[15:8];
    rsp.delete();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_data_o <= q[i];
    end
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_data_o <= ~q[7];
    // Silent interval then reply window, ready toggling each cycle
    repeat (60)
    begin
      @(posedge clk_i);
      if (rsp_valid_i && rsp_ready_o)
        rsp.push_back(rsp_data_i);
      rsp_ready_o <= ~rsp_ready_o;
    end
  endtask
endmodule

//--- test/test_actuator_coil_command_handler.sv
// Self-checking bench for the coil command handler with a host model.
// Assumes handler, checker and host model compiled first; short silent gap.
`timescale 1ns/100ps

module test_actuator_coil_command_handler;
  import ach_pkg::*;
  logic ref_clk_i, srst_i, servo_on_i, moving_i, alarm_reset_i, home_reversed_i;
  logic home_finished_i, teach_present_i, rx_valid_i, tx_ready_i, tx_valid_o;
  logic brake_release_o, motion_hold_o, move_inhibit_o, resume_o, discard_remaining_o;
  logic home_start_o, home_restart_o, homing_done_flag_o, servo_cmd_lock_o;
  logic [3:0] axis_i;
  ach_byte_t rx_data_i, tx_data_o;
  int fails, checks, cyc, n_res, n_dis, n_st, n_rs;

  ach_coil_handler #(.SILENT_NS(200)) u_dut (.*);
  ach_host_model u_host (.clk_i(ref_clk_i), .rsp_valid_i(tx_valid_o), .rsp_data_i(tx_data_o),
    .rsp_ready_o(tx_ready_i), .req_valid_o(rx_valid_i), .req_data_o(rx_data_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Pulse counters and hang limit
  always @(posedge ref_clk_i)
  begin
    cyc++;
    n_res += int'(resume_o);
    n_dis += int'(discard_remaining_o);
    n_st += int'(home_start_o);
    n_rs += int'(home_restart_o);
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    srst_i <= 1'b0;
  endtask

  // Write one coil; e is the expected exception code, r whether a reply comes
  task automatic wr(input ach_byte_t a, f, input logic [15:0] c, d,
    input ach_byte_t e, input bit r);
    u_host.send(a, f, c, d, 1'b0);
    chk(u_host.rsp.size(), r ? (e ? 5 : 8) : 0);
    if (r && e)
    begin
      chk(u_host.rsp[1], f | 8'h80);
      chk(u_host.rsp[2], e);
    end
    else if (r)
      for (int i = 0; i < 8; i++)
        chk(u_host.rsp[i], u_host.q[i]);
  endtask

  task automatic t_lock();
    @(posedge ref_clk_i);
    teach_present_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    teach_present_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    chk(servo_cmd_lock_o, 1'b1);
    do_reset(2);
    @(posedge ref_clk_i);
    chk(servo_cmd_lock_o, 1'b0);
  endtask

  task automatic t_brake();
    wr(8'h01, 8'h05, 16'h0408, 16'hff00, 8'h00, 1'b1);
    chk(brake_release_o, 1'b1);
    wr(8'h01, 8'h05, 16'h0408, 16'h0000, 8'h00, 1'b1);
    chk(brake_release_o, 1'b0);
    @(posedge ref_clk_i);
    servo_on_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(brake_release_o, 1'b1);
  endtask

  task automatic t_addr();
    @(posedge ref_clk_i);
    axis_i <= 4'hf;
    wr(8'h10, 8'h05, 16'h040a, 16'hff00, 8'h00, 1'b1);
    chk(motion_hold_o, 1'b1);
    wr(8'h0f, 8'h05, 16'h040a, 16'h0000, 8'h00, 1'b0);
    chk(motion_hold_o, 1'b1);
    wr(8'h00, 8'h05, 16'h040a, 16'h0000, 8'h00, 1'b0);
    chk(motion_hold_o, 1'b0);
    axis_i <= 4'h0;
  endtask

  task automatic t_refuse();
    u_host.send(8'h01, 8'h05, 16'h040a, 16'hff00, 1'b1);
    chk(u_host.rsp.size(), 0);
    wr(8'h01, 8'h06, 16'h040a, 16'hff00, 8'h01, 1'b1);
    wr(8'h01, 8'h05, 16'h0409, 16'hff00, 8'h02, 1'b1);
    wr(8'h01, 8'h05, 16'h040a, 16'h1234, 8'h03, 1'b1);
    chk(motion_hold_o, 1'b0);
  endtask

  task automatic t_hold();
    int r0;
    @(posedge ref_clk_i);
    moving_i <= 1'b1;
    wr(8'h01, 8'h05, 16'h040a, 16'hff00, 8'h00, 1'b1);
    chk(move_inhibit_o, 1'b1);
    r0 = n_res;
    wr(8'h01, 8'h05, 16'h040a, 16'h0000, 8'h00, 1'b1);
    chk(n_res - r0, 1);
    wr(8'h01, 8'h05, 16'h040a, 16'hff00, 8'h00, 1'b1);
    alarm_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    alarm_reset_i <= 1'b0;
    moving_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(n_dis, 1);
    r0 = n_res;
    wr(8'h01, 8'h05, 16'h040a, 16'h0000, 8'h00, 1'b1);
    chk(n_res - r0, 0);
  endtask

  task automatic t_home();
    wr(8'h01, 8'h05, 16'h040b, 16'h0000, 8'h00, 1'b1);
    wr(8'h01, 8'h05, 16'h040b, 16'hff00, 8'h00, 1'b1);
    wr(8'h01, 8'h05, 16'h040b, 16'hff00, 8'h00, 1'b1);
    chk(n_st, 1);
    home_finished_i <= 1'b1;
    @(posedge ref_clk_i);
    home_finished_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(homing_done_flag_o, 1'b1);
    wr(8'h01, 8'h05, 16'h040b, 16'h0000, 8'h00, 1'b1);
    wr(8'h01, 8'h05, 16'h040b, 16'hff00, 8'h00, 1'b1);
    chk(n_st, 2);
    chk(homing_done_flag_o, 1'b0);
    wr(8'h01, 8'h05, 16'h040a, 16'hff00, 8'h00, 1'b1);
    wr(8'h01, 8'h05, 16'h040a, 16'h0000, 8'h00, 1'b1);
    chk(n_rs, 0);
    home_reversed_i <= 1'b1;
    wr(8'h01, 8'h05, 16'h040a, 16'hff00, 8'h00, 1'b1);
    chk(n_rs, 1);
  endtask

  initial
  begin
    srst_i = 1'b1;
    axis_i = 4'h0;
    servo_on_i = 1'b0;
    moving_i = 1'b0;
    alarm_reset_i = 1'b0;
    home_reversed_i = 1'b0;
    home_finished_i = 1'b0;
    teach_present_i = 1'b0;
    do_reset(20);
    t_lock();
    t_brake();
    t_addr();
    t_refuse();
    t_hold();
    t_home();
    summarize();
  end
endmodule
